// >>> clock_power_pkg.sv
// Package for the clock and power-mode controller: encodings, reset values,
// timing figures and the structs that carry configuration and status.
// Assumes a single 10 MHz control clock; oscillator rates enter as figures.
package clock_power_pkg;

    // ------------------------------------------------------------------
    // Clock rates and timing figures
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 10_000_000;
    localparam int IRC_HZ            = 4_000_000;
    localparam int IRC_START_US      = 60;
    localparam int FLASH_START_US    = 100;
    localparam int IRC_RESUME_RC_CYC = 4;
    localparam int OSC_WAKE_OSC_CYC  = 4096;
    // Least times round up to whole control-clock cycles
    localparam int IRC_START_CYC  = (IRC_START_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int FLASH_CYC      = (FLASH_START_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int IRC_RESUME_CYC = (IRC_RESUME_RC_CYC * CLK_HZ + IRC_HZ - 1) / IRC_HZ;

    // ------------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------------
    localparam int PREDIV_W  = 8;    // Holds N-1, N = 1..256
    localparam int MULT_W    = 15;   // Holds M-1, M = 1..32768
    localparam int CPU_DIV_W = 8;
    localparam int USB_DIV_W = 4;
    localparam int PDIV_W    = 2;    // Peripheral divide code: 1, 2, 4, 8
    localparam int CNT_W     = 16;
    localparam logic [PREDIV_W-1:0]  PREDIV_RST  = 8'h00;
    localparam logic [MULT_W-1:0]    MULT_RST    = 15'h0000;
    localparam logic [CPU_DIV_W-1:0] CPU_DIV_RST = 8'h00;
    localparam logic [USB_DIV_W-1:0] USB_DIV_RST = 4'h0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_IRC  = 2'h0,
        SRC_MAIN = 2'h1,
        SRC_RTC  = 2'h2
    } clk_src_t;

    typedef enum logic [2:0] {
        REQ_IDLE  = 3'h1,
        REQ_SLEEP = 3'h2,
        REQ_PDOWN = 3'h3,
        REQ_DEEP  = 3'h4
    } pwr_req_t;

    typedef enum logic [6:0] {
        ST_RESET = 7'h01,
        ST_RUN   = 7'h02,
        ST_IDLE  = 7'h04,
        ST_SLEEP = 7'h08,
        ST_PDOWN = 7'h10,
        ST_DEEP  = 7'h20,
        ST_WAKE  = 7'h40
    } pwr_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        clk_src_t             src;
        logic                 pll_enable;
        logic                 pll_connect;
        logic [PREDIV_W-1:0]  prediv_m1;
        logic [MULT_W-1:0]    mult_m1;
        logic [CPU_DIV_W-1:0] cpu_div;
        logic [USB_DIV_W-1:0] usb_div;
    } clk_cfg_t;

    typedef struct packed {
        logic cpu_run;
        logic clocks_run;
        logic irc_out_en;
        logic irc_powered;
        logic main_osc_power;
        logic main_osc_stable;
        logic flash_powered;
        logic flash_ready;
        logic regulator_on;
        logic rtc_osc_run;
    } pwr_stat_t;

endpackage

// >>> clock_power_mode_control.sv
// Clock source selection, PLL control sequencing, peripheral clock gating
// and processor power-mode sequencing, all in one control clock domain.
// Assumes every input is synchronous to mclk and the analog blocks obey
// the enables and powers driven from here.
`timescale 1ns/1ps

module clock_power_mode_control #(
    parameter int NUM_PERIPH  = 8,
    parameter int MAIN_OSC_HZ = 12_000_000
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst_n,
    input  wire logic                                 cfg_wr,
    input  wire clock_power_pkg::clk_cfg_t            cfg_in,
    input  wire logic                                 periph_wr,
    input  wire logic [NUM_PERIPH-1:0]                periph_gate_in,
    input  wire logic [NUM_PERIPH*clock_power_pkg::PDIV_W-1:0] periph_div_in,
    input  wire logic                                 mode_req,
    input  wire clock_power_pkg::pwr_req_t            mode_code,
    input  wire logic                                 any_irq,
    input  wire logic                                 wake_irq,
    input  wire logic                                 rtc_alarm,
    input  wire logic                                 main_osc_running,
    input  wire logic                                 pll_lock,
    output clock_power_pkg::clk_cfg_t                 cfg_state,
    output clock_power_pkg::clk_src_t                 cpu_src,
    output logic                                      cpu_from_pll,
    output logic                                      pll_lock_status,
    output clock_power_pkg::pwr_stat_t                stat,
    output logic                                      internal_reset_n,
    output clock_power_pkg::pwr_state_t               mode_state,
    output logic [NUM_PERIPH-1:0]                     periph_clk_en
);
    import clock_power_pkg::*;

    // Main oscillator cycles converted to control-clock cycles, rounded up
    localparam longint OSC_WAKE_L =
        (longint'(OSC_WAKE_OSC_CYC) * CLK_HZ + MAIN_OSC_HZ - 1) / MAIN_OSC_HZ;
    localparam logic [CNT_W-1:0] OSC_WAKE_CYC    = CNT_W'(OSC_WAKE_L);
    localparam logic [CNT_W-1:0] SLEEP_IRC_CYC   = CNT_W'(IRC_RESUME_CYC);
    localparam logic [CNT_W-1:0] PDOWN_WAKE_CYC  = CNT_W'(IRC_START_CYC + IRC_RESUME_CYC);
    localparam logic [CNT_W-1:0] FLASH_RST_CYC   = CNT_W'(FLASH_CYC);
    localparam logic [CNT_W-1:0] FLASH_PD_CYC    = CNT_W'(IRC_START_CYC + FLASH_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO        = 16'h0000;

    pwr_state_t            state;
    logic [CNT_W-1:0]      wait_cnt;
    logic [CNT_W-1:0]      flash_cnt;
    logic [CNT_W-1:0]      osc_cnt;
    logic                  osc_stable;
    logic                  flash_ok;
    logic [NUM_PERIPH-1:0] periph_gate;
    logic [NUM_PERIPH*PDIV_W-1:0] periph_div;
    logic                  enter_sleep;
    logic                  enter_pdown;
    logic                  deep_exit;
    logic                  stopped;
    logic                  osc_power;

    // ------------------------------------------------------------------
    // Mode events
    // ------------------------------------------------------------------
    // Power-down and deep power-down both pass through the sleep actions
    assign enter_sleep = (state == ST_RUN) && mode_req &&
                         (mode_code == REQ_SLEEP || mode_code == REQ_PDOWN ||
                          mode_code == REQ_DEEP);
    assign enter_pdown = (state == ST_RUN) && mode_req &&
                         (mode_code == REQ_PDOWN || mode_code == REQ_DEEP);
    assign deep_exit   = (state == ST_DEEP) && rtc_alarm;
    assign stopped     = (state == ST_SLEEP) || (state == ST_PDOWN) || (state == ST_DEEP);
    // Oscillator runs while selected outside sleep, power-down and deep power-down, and during reset so it can be qualified
    assign osc_power   = !stopped && (state == ST_RESET || cfg_state.src == SRC_MAIN);

    // ------------------------------------------------------------------
    // Power-mode sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_RESET;
            wait_cnt <= CNT_ZERO;
        end else begin
            unique case (state)
                ST_RESET: begin
                    if (osc_stable && flash_ok) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (mode_req) begin
                        unique case (mode_code)
                            REQ_IDLE:  state <= ST_IDLE;
                            REQ_SLEEP: state <= ST_SLEEP;
                            REQ_PDOWN: state <= ST_PDOWN;
                            REQ_DEEP:  state <= ST_DEEP;
                            default:   state <= ST_RUN;
                        endcase
                    end
                end
                ST_IDLE: begin
                    if (any_irq) begin
                        state <= ST_RUN;
                    end
                end
                ST_SLEEP: begin
                    if (wake_irq) begin
                        state    <= ST_WAKE;
                        // RC resumes quickly; the crystal must ramp up again
                        wait_cnt <= (cfg_state.src == SRC_MAIN) ?
                                    OSC_WAKE_CYC : SLEEP_IRC_CYC;
                    end
                end
                ST_PDOWN: begin
                    if (wake_irq) begin
                        state    <= ST_WAKE;
                        wait_cnt <= PDOWN_WAKE_CYC;
                    end
                end
                ST_DEEP: begin
                    if (rtc_alarm) begin
                        state <= ST_RESET;
                    end
                end
                ST_WAKE: begin
                    if (wait_cnt <= 16'h0001) begin
                        state    <= ST_RUN;
                        wait_cnt <= CNT_ZERO;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock configuration
    // ------------------------------------------------------------------
    // Mode entry wins over a write in the same cycle; software reprograms
    // PLL and dividers after waking.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_state.src         <= SRC_IRC;
            cfg_state.pll_enable  <= 1'b0;
            cfg_state.pll_connect <= 1'b0;
            cfg_state.prediv_m1   <= PREDIV_RST;
            cfg_state.mult_m1     <= MULT_RST;
            cfg_state.cpu_div     <= CPU_DIV_RST;
            cfg_state.usb_div     <= USB_DIV_RST;
        end else if (deep_exit) begin
            // Nothing survives the regulator being off
            cfg_state.src         <= SRC_IRC;
            cfg_state.pll_enable  <= 1'b0;
            cfg_state.pll_connect <= 1'b0;
            cfg_state.prediv_m1   <= PREDIV_RST;
            cfg_state.mult_m1     <= MULT_RST;
            cfg_state.cpu_div     <= CPU_DIV_RST;
            cfg_state.usb_div     <= USB_DIV_RST;
        end else if (enter_sleep) begin
            cfg_state.pll_enable  <= 1'b0;
            cfg_state.pll_connect <= 1'b0;
            cfg_state.cpu_div     <= CPU_DIV_RST;
            cfg_state.usb_div     <= USB_DIV_RST;
            if (enter_pdown) begin
                cfg_state.src <= SRC_IRC;
            end
        end else if (cfg_wr) begin
            // Unused source code 3 leaves the selection unchanged
            if (cfg_in.src == SRC_IRC || cfg_in.src == SRC_MAIN ||
                cfg_in.src == SRC_RTC) begin
                cfg_state.src <= cfg_in.src;
            end
            cfg_state.pll_enable  <= cfg_in.pll_enable;
            cfg_state.pll_connect <= cfg_in.pll_connect && cfg_in.pll_enable &&
                                     pll_lock;
            cfg_state.prediv_m1   <= cfg_in.prediv_m1;
            cfg_state.mult_m1     <= cfg_in.mult_m1;
            cfg_state.cpu_div     <= cfg_in.cpu_div;
            cfg_state.usb_div     <= cfg_in.usb_div;
        end
    end

    // ------------------------------------------------------------------
    // Clock routing and PLL status
    // ------------------------------------------------------------------
    // Main oscillator is held off the core until the wake-up timer expires
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_src         <= SRC_IRC;
            cpu_from_pll    <= 1'b0;
            pll_lock_status <= 1'b0;
        end else begin
            if (state == ST_RESET ||
                (cfg_state.src == SRC_MAIN && !osc_stable)) begin
                cpu_src <= SRC_IRC;
            end else begin
                cpu_src <= cfg_state.src;
            end
            cpu_from_pll    <= cfg_state.pll_enable && cfg_state.pll_connect;
            pll_lock_status <= cfg_state.pll_enable && pll_lock;
        end
    end

    // ------------------------------------------------------------------
    // Wake-up timer for the main oscillator
    // ------------------------------------------------------------------
    // Restarts whenever the oscillator is unpowered or drops out
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt    <= OSC_WAKE_CYC;
            osc_stable <= 1'b0;
        end else if (!stat.main_osc_power || !main_osc_running) begin
            osc_cnt    <= OSC_WAKE_CYC;
            osc_stable <= 1'b0;
        end else if (osc_cnt <= 16'h0001) begin
            osc_cnt    <= CNT_ZERO;
            osc_stable <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Flash wake-up counter
    // ------------------------------------------------------------------
    // After power-down the count covers RC start-up and then flash start-up
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt <= FLASH_RST_CYC;
            flash_ok  <= 1'b0;
        end else if (enter_pdown) begin
            flash_cnt <= FLASH_PD_CYC;
            flash_ok  <= 1'b0;
        end else if (deep_exit) begin
            flash_cnt <= FLASH_RST_CYC;
            flash_ok  <= 1'b0;
        end else if (state != ST_PDOWN && state != ST_DEEP && !flash_ok) begin
            if (flash_cnt <= 16'h0001) begin
                flash_cnt <= CNT_ZERO;
                flash_ok  <= 1'b1;
            end else begin
                flash_cnt <= flash_cnt - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power and status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat             <= '0;
            internal_reset_n <= 1'b0;
            mode_state       <= ST_RESET;
        end else begin
            stat.cpu_run         <= (state == ST_RUN);
            stat.clocks_run      <= (state == ST_RUN) || (state == ST_IDLE);
            stat.irc_out_en      <= !stopped;
            stat.irc_powered     <= (state != ST_PDOWN) && (state != ST_DEEP);
            stat.main_osc_power  <= osc_power;
            stat.main_osc_stable <= osc_stable;
            stat.flash_powered   <= (state != ST_PDOWN) && (state != ST_DEEP);
            stat.flash_ready     <= flash_ok;
            stat.regulator_on    <= (state != ST_DEEP);
            stat.rtc_osc_run     <= 1'b1;
            internal_reset_n     <= (state != ST_RESET);
            mode_state           <= state;
        end
    end

    // ------------------------------------------------------------------
    // Peripheral gates and dividers
    // ------------------------------------------------------------------
    // Settings survive sleep; only deep power-down clears them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            periph_gate <= '1;
            periph_div  <= '0;
        end else if (deep_exit) begin
            periph_gate <= '1;
            periph_div  <= '0;
        end else if (periph_wr) begin
            periph_gate <= periph_gate_in;
            periph_div  <= periph_div_in;
        end
    end

    // One enable pulse per divided period for each peripheral
    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
        logic [2:0] div_cnt;
        logic [2:0] div_mask;
        assign div_mask = 3'((4'h1 << periph_div[i*PDIV_W +: PDIV_W]) - 4'h1);

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                div_cnt          <= 3'h0;
                periph_clk_en[i] <= 1'b0;
            end else begin
                div_cnt          <= div_cnt + 3'h1;
                periph_clk_en[i] <= periph_gate[i] && stat.clocks_run &&
                                    ((div_cnt & div_mask) == 3'h0);
            end
        end
    end

endmodule

// >>> osc_pll_model.sv
// Oscillator and PLL lock model at the far side of the controller.
// Assumes power and enable levels come straight from the controller.
`timescale 1ns/1ps
module osc_pll_model #(
    parameter int OSC_DLY  = 20,
    parameter int LOCK_DLY = 40
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic osc_power,
    input  wire logic pll_en,
    output logic      osc_run,
    output logic      pll_lock
);
    int osc_cnt;
    int lock_cnt;
    // Amplitude and lock build slowly; loss of power or enable drops them at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt  <= 0;
            lock_cnt <= 0;
        end else begin
            osc_cnt  <= osc_power ? (osc_cnt < OSC_DLY ? osc_cnt + 1 : osc_cnt) : 0;
            lock_cnt <= pll_en ? (lock_cnt < LOCK_DLY ? lock_cnt + 1 : lock_cnt) : 0;
        end
    end
    assign osc_run  = osc_cnt >= OSC_DLY;
    assign pll_lock = lock_cnt >= LOCK_DLY;
endmodule

// >>> clock_power_checker.sv
// Port checker for the clock and power-mode controller, bound to its top.
// Assumes the single mclk domain with asynchronous rst_n.
`timescale 1ns/1ps
module clock_power_checker #(parameter int NUM_PERIPH = 8) (
    input wire logic                        mclk, rst_n, any_irq, pll_lock,
    input wire logic                        cpu_from_pll, internal_reset_n,
    input wire clock_power_pkg::clk_cfg_t   cfg_state,
    input wire clock_power_pkg::clk_src_t   cpu_src,
    input wire clock_power_pkg::pwr_stat_t  stat,
    input wire clock_power_pkg::pwr_state_t mode_state,
    input wire logic [NUM_PERIPH-1:0]       periph_clk_en
);
    import clock_power_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rst_exit; $rose(internal_reset_n) |-> cpu_src == SRC_IRC && !cpu_from_pll
        && stat.main_osc_stable && stat.flash_ready; endproperty
    a_rst_exit: assert property (p_rst_exit) else $error("bad reset exit");
    property p_pll_path; cpu_from_pll |-> $past(cfg_state.pll_enable && cfg_state.pll_connect);
    endproperty
    a_pll_path: assert property (p_pll_path) else $error("pll path w/o enable");
    property p_connect; $rose(cfg_state.pll_connect) |-> $past(pll_lock); endproperty
    a_connect: assert property (p_connect) else $error("connect w/o lock");
    property p_entry_clr; mode_state inside {ST_SLEEP, ST_PDOWN, ST_DEEP} |-> !cfg_state.pll_enable
        && !cfg_state.pll_connect && cfg_state.cpu_div == '0 && cfg_state.usb_div == '0;
    endproperty
    a_entry_clr: assert property (p_entry_clr) else $error("config kept in low power");
    property p_sleep; mode_state == ST_SLEEP |-> !stat.clocks_run && !stat.cpu_run
        && !stat.irc_out_en && stat.irc_powered && stat.flash_powered && stat.rtc_osc_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep status wrong");
    property p_pdown; mode_state == ST_PDOWN |-> !stat.irc_powered && !stat.flash_powered
        && cfg_state.src == SRC_IRC; endproperty
    a_pdown: assert property (p_pdown) else $error("power-down status wrong");
    property p_deep; mode_state == ST_DEEP |-> !stat.regulator_on; endproperty
    a_deep: assert property (p_deep) else $error("regulator on in deep");
    property p_idle; mode_state == ST_IDLE && any_irq |-> ##[1:3] mode_state == ST_RUN;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not left on irq");
    property p_periph; periph_clk_en != '0 |-> stat.clocks_run || $past(stat.clocks_run);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral clock while stopped");
    // Main scenarios reached
    c_pll: cover property (cpu_from_pll);
    c_wake: cover property (mode_state == ST_WAKE);
    c_deep: cover property (mode_state == ST_DEEP);
endmodule
bind clock_power_mode_control clock_power_checker #(.NUM_PERIPH(NUM_PERIPH)) u_clock_power_checker (
    .mclk(mclk), .rst_n(rst_n), .any_irq(any_irq), .pll_lock(pll_lock),
    .cpu_from_pll(cpu_from_pll), .internal_reset_n(internal_reset_n), .cfg_state(cfg_state),
    .cpu_src(cpu_src), .stat(stat), .mode_state(mode_state), .periph_clk_en(periph_clk_en));

// >>> clock_power_mode_control_test.sv
// Self-checking bench for the clock and power-mode controller.
// Assumes the oscillator and PLL model and the bound port checker.
`timescale 1ns/1ps
module clock_power_mode_control_test;
    import clock_power_pkg::*;
    localparam int MAIN_HZ = 12_000_000;
    localparam int OSC_W = int'((64'(OSC_WAKE_OSC_CYC) * CLK_HZ + MAIN_HZ - 1) / MAIN_HZ);
    logic       mclk, rst_n, cfg_wr, periph_wr, mode_req, any_irq, wake_irq, rtc_alarm;
    logic       osc_run, lock, from_pll, lock_st, irst_n;
    logic [7:0] gate_in, clk_en;
    logic [15:0] div_in;
    clk_cfg_t   cfg_in, cfg_state;
    clk_src_t   cpu_src;
    pwr_req_t   code;
    pwr_stat_t  stat;
    pwr_state_t mstate;
    int         err_count, checked, cyc;
    clock_power_mode_control #(.MAIN_OSC_HZ(MAIN_HZ)) u_clock_power_mode_control (
        .mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .periph_wr(periph_wr),
        .periph_gate_in(gate_in), .periph_div_in(div_in), .mode_req(mode_req),
        .mode_code(code), .any_irq(any_irq), .wake_irq(wake_irq), .rtc_alarm(rtc_alarm),
        .main_osc_running(osc_run), .pll_lock(lock), .cfg_state(cfg_state), .cpu_src(cpu_src),
        .cpu_from_pll(from_pll), .pll_lock_status(lock_st), .stat(stat),
        .internal_reset_n(irst_n), .mode_state(mstate), .periph_clk_en(clk_en));
    osc_pll_model u_osc_pll_model (.mclk(mclk), .rst_n(rst_n), .osc_power(stat.main_osc_power),
        .pll_en(cfg_state.pll_enable), .osc_run(osc_run), .pll_lock(lock));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Two extra settle cycles so the derived source outputs have landed
    task automatic wr(input clk_cfg_t c);
        @(negedge mclk) cfg_in = c;
        cfg_wr = 1;
        @(negedge mclk) cfg_wr = 0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic req(input pwr_req_t c);
        @(negedge mclk) code = c;
        mode_req = 1;
        @(negedge mclk) mode_req = 0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic wait_st(input pwr_state_t s, output int n);
        n = 0;
        while (mstate !== s && n < 5000) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic wake(input int lo, input int hi);
        int n;
        @(negedge mclk) wake_irq = 1;
        wait_st(ST_WAKE, n);
        wake_irq = 0;
        wait_st(ST_RUN, n);
        chk(n >= lo && n <= hi, 1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_src();
        clk_cfg_t c = '0;
        for (int i = 0; i < 4; i++) begin
            c.src = clk_src_t'(i);
            wr(c);
            chk(cpu_src, i == 1 ? 0 : (i == 3 ? 2 : i));
            // Main source reaches the core only once the wake-up timer expires
            if (i == 1) begin
                while (stat.main_osc_stable !== 1'b1) @(negedge mclk);
                chk(cpu_src, 1);
            end
        end
    endtask
    task automatic t_pll();
        clk_cfg_t c = '0;
        int n = 0;
        c.prediv_m1 = 8'hFF;
        c.mult_m1 = 15'h7FFF;
        wr(c);
        chk(cfg_state.prediv_m1, 8'hFF);
        chk(cfg_state.mult_m1, 15'h7FFF);
        c = '0;
        c.mult_m1 = 15'h0063; // 4 MHz times 100 stays inside the oscillator band
        c.pll_enable = 1;
        c.pll_connect = 1;
        wr(c);
        chk(cfg_state.pll_connect, 0);
        while (lock_st !== 1'b1 && n++ < 500) @(negedge mclk);
        chk(lock_st, 1);
        wr(c);
        chk(from_pll, 1);
    endtask
    task automatic t_sleep(input clk_src_t s, input int lo, input int hi);
        clk_cfg_t c = '0;
        c.src = s;
        c.pll_enable = 1;
        c.cpu_div = 8'h03;
        c.usb_div = 4'h5;
        wr(c);
        req(REQ_SLEEP);
        chk(mstate, ST_SLEEP);
        chk({cfg_state.pll_enable, cfg_state.cpu_div, cfg_state.usb_div}, 0);
        chk({stat.clocks_run, stat.flash_powered, stat.main_osc_power}, 3'h2);
        wake(lo, hi);
        // Dividers were cleared on entry, so software writes them again
        wr(c);
        chk(cfg_state.cpu_div, 8'h03);
    endtask
    task automatic t_modes();
        int n;
        req(REQ_PDOWN);
        chk({stat.irc_powered, stat.flash_powered}, 0);
        wake(IRC_START_CYC + IRC_RESUME_CYC, IRC_START_CYC + IRC_RESUME_CYC);
        chk({stat.flash_ready, cpu_src}, SRC_IRC);
        wait_st(mstate, n);
        while (stat.flash_ready !== 1'b1 && n < 2000) @(negedge mclk) n++;
        chk(n, FLASH_CYC - IRC_RESUME_CYC);
        req(REQ_IDLE);
        chk({stat.cpu_run, stat.clocks_run}, 1);
        @(negedge mclk) any_irq = 1;
        wait_st(ST_RUN, n);
        any_irq = 0;
        chk(n <= 3, 1);
    endtask
    task automatic t_periph();
        int cnt = 0;
        int bad = 0;
        @(negedge mclk) gate_in = 8'h81;
        div_in = 16'h8002;
        periph_wr = 1;
        @(negedge mclk) periph_wr = 0;
        repeat (64) @(negedge mclk) begin
            cnt += clk_en[0];
            bad += (clk_en[6:1] != 6'h00);
        end
        chk(cnt, 16);
        chk(bad, 0);
    endtask
    task automatic t_deep();
        clk_cfg_t c = '0;
        int n;
        c.src = SRC_MAIN;
        wr(c);
        req(REQ_DEEP);
        chk(stat.regulator_on, 0);
        @(negedge mclk) wake_irq = 1;
        repeat (8) @(negedge mclk);
        chk(mstate, ST_DEEP);
        wake_irq = 0;
        rtc_alarm = 1;
        wait_st(ST_RESET, n);
        rtc_alarm = 0;
        wait_st(ST_RUN, n);
        chk({cfg_state.src, cpu_src}, 0);
    endtask
    // ------------------------------------------------------------
    // Clock, hang guard and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    // Whole run needs about 15000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        int n;
        {rst_n, cfg_wr, periph_wr, mode_req, any_irq, wake_irq, rtc_alarm} = '0;
        cfg_in = '0;
        gate_in = 8'hFF;
        div_in = 16'h0000;
        code = REQ_IDLE;
        repeat (16) @(negedge mclk);
        rst_n = 1;
        wait_st(ST_RUN, n);
        chk({irst_n, cpu_src, from_pll, cfg_state.pll_enable}, 5'h10);
        t_src();
        t_pll();
        t_sleep(SRC_IRC, IRC_RESUME_CYC, IRC_RESUME_CYC);
        t_sleep(SRC_MAIN, OSC_W, OSC_W + 30);
        t_modes();
        t_periph();
        t_deep();
        wrap_up();
    end
endmodule
